// ===== src/pwm_unit.sv
// PWM unit: register port, period timer, double-buffered duty and pin drive.
// Assumes a single 200 MHz clk_sys standing in for the oscillator, and a
// sleep request pin from outside the clock domain.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "pwm_consts.svh"

// Summary of operation
// - Duty is double-buffered in shadow byte plus two-bit latch, updated between periods.
// - Ten-bit time base is the timer count extended by two low bits.
// - At prescale 1:1 the low bits are oscillator phase, otherwise prescaler bits.
// - Pin goes low when the time base equals the buffered duty.
// - High time is duty times oscillator period times prescale factor.
// - Resolution is log2 of four times period plus one, ten bits at 255.
// - Duty beyond the period leaves the pin unchanged for the period.
// - Prescaler divides by 1, 4 or 16.
// - Sleep stops the timer and holds all state and pin level.
// - Reset restores register defaults and makes the pin an input.
// - After timer equals period: clear timer, set pin unless duty zero, load shadow.
// - Duty takes high eight bits from duty byte, low two from control.
// - Shadow byte is read-only while in PWM mode.
// - Period is period limit plus one times four times prescale; postscale unused.
module pwm_unit (
  input  wire logic               clk_sys,
  input  wire logic               arst_n,
  input  wire pwm_pkg::reg_addr_t reg_addr,
  input  wire pwm_pkg::reg_byte_t reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output pwm_pkg::reg_byte_t      reg_rdata,
  input  wire logic               sleep_req,
  output logic                    pwm_output_pin,
  output logic                    pwm_output_pin_oe,
  output logic                    alt_pin_sel,
  output logic                    timer_match_flag
);
  // Software-visible registers
  pwm_pkg::reg_byte_t unit_control;
  pwm_pkg::reg_byte_t duty_high_byte;
  pwm_pkg::reg_byte_t duty_shadow_byte;
  pwm_pkg::reg_byte_t period_limit;
  logic [6:0]         period_timer_control;
  pwm_pkg::reg_byte_t period_timer_count;
  logic               pin_direction;

  // Internal state
  logic [1:0]         duty_latch;
  logic               pin_level;
  logic               sleep_meta;
  logic               sleep_sync;
  logic               first_cycle;
  logic               boundary_q;

  // Decoded controls
  logic               pwm_active;
  logic               rollover;
  logic               duty_match;
  logic               wr_count;
  logic [9:0]         duty_full;
  pwm_pkg::time_base_t time_base;
  pwm_pkg::time_base_t duty_buf;
  pwm_pkg::time_base_t period_end;

  pwm_timebase_if tb_link ();

  pwm_timebase_gen u_timebase (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .tb      (tb_link.gen)
  );

  // Sleep request crosses in from outside through two flip-flops
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end
    else
    begin
      sleep_meta <= sleep_req;
      sleep_sync <= sleep_meta;
    end
  end

  // Controls towards the time base; postscale bits are stored but unused here
  assign tb_link.run          = period_timer_control[`TCTL_RUN_BIT];
  assign tb_link.freeze       = sleep_sync;
  assign tb_link.prescale_sel = period_timer_control[`TCTL_PRESC_HI:`TCTL_PRESC_LO];

  // Mode decode and compare terms
  assign pwm_active = (unit_control[`CTRL_MODE_HI:`CTRL_MODE_LO] & `MODE_PWM_MASK)
                      == `MODE_PWM_CODE;
  assign duty_full  = {duty_high_byte,
                       unit_control[`CTRL_DUTY_LSB_HI:`CTRL_DUTY_LSB_LO]};
  // Full ten bits of compare only exist when the period limit is 255
  assign time_base  = {period_timer_count, tb_link.low_bits};
  assign duty_buf   = {duty_shadow_byte, duty_latch};
  assign period_end = {period_limit, 2'h3};
  assign rollover   = tb_link.tick && period_timer_count == period_limit;
  assign duty_match = pwm_active && tb_link.run && time_base == duty_buf;
  assign wr_count   = reg_wr && reg_addr == `ADDR_TIMER_COUNT;

  // Control, duty byte, period, timer control and pin function registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      unit_control         <= `RST_BYTE;
      duty_high_byte       <= `RST_BYTE;
      period_limit         <= `RST_BYTE;
      period_timer_control <= `RST_TIMER_CONTROL;
      pin_direction        <= `RST_PIN_DIRECTION;
      alt_pin_sel          <= 1'b0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `ADDR_UNIT_CONTROL:   unit_control <= {2'h0, reg_wdata[5:0]};
        `ADDR_DUTY_HIGH_BYTE: duty_high_byte <= reg_wdata;
        `ADDR_PERIOD_LIMIT:   period_limit <= reg_wdata;
        `ADDR_TIMER_CONTROL:  period_timer_control <= reg_wdata[6:0];
        `ADDR_PIN_DIRECTION:  pin_direction <= reg_wdata[0];
        `ADDR_PIN_FUNCTION:   alt_pin_sel <= reg_wdata[0];
        default:              ;
      endcase
    end
  end

  // Period timer; a software write wins over the increment in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      period_timer_count <= `RST_BYTE;
    else if (wr_count)
      period_timer_count <= reg_wdata;
    else if (rollover)
      period_timer_count <= `RST_BYTE;
    else if (tb_link.tick)
      period_timer_count <= period_timer_count + 8'h01;
  end

  // Duty buffer: in PWM mode loaded only at the period boundary so no glitch reaches the pin
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      duty_shadow_byte <= `RST_BYTE;
      duty_latch       <= 2'h0;
    end
    else if (pwm_active && rollover)
    begin
      duty_shadow_byte <= duty_high_byte;
      duty_latch       <= duty_full[1:0];
    end
    else if (!pwm_active && reg_wr && reg_addr == `ADDR_DUTY_SHADOW_BYTE)
      duty_shadow_byte <= reg_wdata;
  end

  // Period start flag, one clock after the boundary tick; the clear is also
  // one clock after its match, so the high time is exactly the duty count
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      boundary_q <= 1'b0;
    else
      boundary_q <= pwm_active && rollover;
  end

  // Pin level: set at the period start, cleared on duty match; a duty beyond
  // the period never matches, so the level simply stands
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      pin_level <= 1'b0;
    else if (!pwm_active)
      pin_level <= 1'b0;
    else if (boundary_q)
      pin_level <= duty_buf != 10'h000;
    else if (duty_match)
      pin_level <= 1'b0;
  end

  // Match flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      timer_match_flag <= 1'b0;
    else if (rollover)
      timer_match_flag <= 1'b1;
    else if (reg_wr && reg_addr == `ADDR_MATCH_STATUS)
      timer_match_flag <= reg_wdata[0];
  end

  // Pin is driven only in PWM mode with the direction bit cleared
  assign pwm_output_pin    = pin_level;
  assign pwm_output_pin_oe = pwm_active && !pin_direction;

  // Read data appear in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= `RST_BYTE;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `ADDR_UNIT_CONTROL:     reg_rdata <= unit_control;
        `ADDR_DUTY_HIGH_BYTE:   reg_rdata <= duty_high_byte;
        `ADDR_DUTY_SHADOW_BYTE: reg_rdata <= duty_shadow_byte;
        `ADDR_PERIOD_LIMIT:     reg_rdata <= period_limit;
        `ADDR_TIMER_CONTROL:    reg_rdata <= {1'b0, period_timer_control};
        `ADDR_TIMER_COUNT:      reg_rdata <= period_timer_count;
        `ADDR_MATCH_STATUS:     reg_rdata <= {7'h00, timer_match_flag};
        `ADDR_PIN_DIRECTION:    reg_rdata <= {7'h00, pin_direction};
        `ADDR_PIN_FUNCTION:     reg_rdata <= {7'h00, alt_pin_sel};
        default:                reg_rdata <= `RST_BYTE;
      endcase
    end
  end

  // Helper for checking the state right after reset release
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      first_cycle <= 1'b1;
    else
      first_cycle <= 1'b0;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // Buffered duty moves only at a period boundary while in PWM mode
  property p_duty_buffer_hold;
    (pwm_active && !rollover) |=> $stable(duty_buf);
  endproperty
  a_duty_buffer_hold: assert property (p_duty_buffer_hold)
    else $error("Buffered duty changed inside a period");

  // Boundary clears timer and loads shadow from the duty byte
  property p_rollover_effects;
    (pwm_active && rollover && !wr_count && !reg_wr) |=>
      (period_timer_count == 8'h00 && duty_shadow_byte == $past(duty_high_byte));
  endproperty
  a_rollover_effects: assert property (p_rollover_effects)
    else $error("Period boundary effects missing");

  // Pin is set at the period start unless the buffered duty is zero
  property p_period_start;
    (boundary_q && pwm_active) |=> pin_level == ($past(duty_buf) != 10'h000);
  endproperty
  a_period_start: assert property (p_period_start)
    else $error("Pin not set per duty at period start");

  // Match between time base and buffered duty drops the pin
  property p_match_clears;
    (duty_match && !rollover && pwm_active && !reg_wr) |=> !pin_level;
  endproperty
  a_match_clears: assert property (p_match_clears)
    else $error("Pin not cleared on duty match");

  // Duty beyond the period leaves the pin alone inside the period
  property p_overlong_duty;
    (pwm_active && duty_buf > period_end && !rollover && !boundary_q && !reg_wr)
      |=> $stable(pin_level);
  endproperty
  a_overlong_duty: assert property (p_overlong_duty)
    else $error("Pin changed with duty beyond period");

  // At 1:1 the low bits step every clock while running
  property p_phase_low_bits;
    (tb_link.run && !sleep_sync && tb_link.prescale_sel == 2'h0 && !reg_wr)
      ##1 (tb_link.run && !sleep_sync) |-> tb_link.low_bits == $past(tb_link.low_bits) + 2'h1;
  endproperty
  a_phase_low_bits: assert property (p_phase_low_bits)
    else $error("Low bits not following oscillator phase");

  // Sleep freezes timer and pin
  property p_sleep_freeze;
    (sleep_sync && !boundary_q && !reg_wr) |=>
      ($stable(period_timer_count) && $stable(pin_level));
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze)
    else $error("State moved during sleep");

  // After reset the pin is an input and registers are at defaults
  property p_reset_defaults;
    first_cycle |-> (!pwm_output_pin_oe && period_timer_count == 8'h00 && pin_direction);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("Register defaults wrong after reset");

  // Duty byte write is stored
  property p_duty_write;
    (reg_wr && reg_addr == `ADDR_DUTY_HIGH_BYTE) |=> duty_high_byte == $past(reg_wdata);
  endproperty
  a_duty_write: assert property (p_duty_write)
    else $error("Duty byte write lost");

  // Shadow byte ignores software writes in PWM mode
  property p_shadow_readonly;
    (pwm_active && !rollover && reg_wr && reg_addr == `ADDR_DUTY_SHADOW_BYTE) |=>
      duty_shadow_byte == $past(duty_shadow_byte);
  endproperty
  a_shadow_readonly: assert property (p_shadow_readonly)
    else $error("Shadow byte written in PWM mode");

  // No drive and no level outside PWM mode
  property p_mode_gates_pin;
    !pwm_active |-> ##1 (!pwm_output_pin_oe || pwm_active) && (!pin_level || pwm_active);
  endproperty
  a_mode_gates_pin: assert property (p_mode_gates_pin)
    else $error("Pin active outside PWM mode");

  // A rising pin only ever starts at a period boundary
  property p_rise_at_boundary;
    $rose(pin_level) |-> $past(boundary_q);
  endproperty
  a_rise_at_boundary: assert property (p_rise_at_boundary)
    else $error("Pin rose away from a period boundary");

  c_boundary:  cover property (pwm_active && rollover && duty_full != 10'h000);
  c_pin_fall:  cover property (pwm_active && $fell(pin_level));
  c_sleeping:  cover property (sleep_sync && pwm_active && tb_link.run);
  c_div16_run: cover property (tb_link.tick && tb_link.prescale_sel == 2'h2);
endmodule : pwm_unit

// ===== src/pwm_consts.svh
// Register map, field positions and reset values of the PWM unit.
// Assumes an 8-bit register port with a 4-bit word address.
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH

// Register addresses
`define ADDR_UNIT_CONTROL      4'h0
`define ADDR_DUTY_HIGH_BYTE    4'h1
`define ADDR_DUTY_SHADOW_BYTE  4'h2
`define ADDR_PERIOD_LIMIT      4'h3
`define ADDR_TIMER_CONTROL     4'h4
`define ADDR_TIMER_COUNT       4'h5
`define ADDR_MATCH_STATUS      4'h6
`define ADDR_PIN_DIRECTION     4'h7
`define ADDR_PIN_FUNCTION      4'h8

// Field positions
`define CTRL_DUTY_LSB_HI       5
`define CTRL_DUTY_LSB_LO       4
`define CTRL_MODE_HI           3
`define CTRL_MODE_LO           0
`define TCTL_POST_HI           6
`define TCTL_POST_LO           3
`define TCTL_RUN_BIT           2
`define TCTL_PRESC_HI          1
`define TCTL_PRESC_LO          0

// Mode and prescale encodings
`define MODE_PWM_MASK          4'hc
`define MODE_PWM_CODE          4'hc
`define PRESC_DIV1             2'h0
`define PRESC_DIV4             2'h1

// Reset values and counter last values
`define RST_BYTE               8'h00
`define RST_TIMER_CONTROL      7'h00
`define RST_PIN_DIRECTION      1'h1
`define PHASE_LAST             2'h3
`define PRESC_LAST             4'hf

`endif

// ===== src/pwm_pkg.sv
// Shared types of the PWM unit.
// Assumes nothing beyond a SystemVerilog compiler.
package pwm_pkg;
  typedef logic [3:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [9:0] time_base_t;
  typedef logic [1:0] prescale_sel_t;
endpackage : pwm_pkg

// ===== src/pwm_timebase_if.sv
// Link between the register side and the time base generator.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface pwm_timebase_if;
  logic                  run;
  logic                  freeze;
  pwm_pkg::prescale_sel_t prescale_sel;
  logic                  tick;
  logic [1:0]            low_bits;

  modport ctrl (output run, output freeze, output prescale_sel, input tick, input low_bits);
  modport gen  (input run, input freeze, input prescale_sel, output tick, output low_bits);
endinterface : pwm_timebase_if

// ===== src/pwm_timebase_gen.sv
// Oscillator phase counter and timer prescaler.
// Assumes run, freeze and prescale_sel come from clk_sys flip-flops.
`timescale 1ns/1ps
`include "pwm_consts.svh"
module pwm_timebase_gen (
  input  wire logic      clk_sys,
  input  wire logic      arst_n,
  pwm_timebase_if.gen    tb
);
  logic [1:0] phase;
  logic [3:0] presc;
  logic       step;

  // Phase and prescaler stop while frozen, so the time base resumes in place
  assign step = tb.run && !tb.freeze;

  // One oscillator phase per clock; four phases make one instruction cycle
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      phase <= 2'h0;
    else if (step)
      phase <= phase + 2'h1;
  end

  // Prescaler advances once per instruction cycle
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      presc <= 4'h0;
    else if (step && phase == `PHASE_LAST)
      presc <= presc + 4'h1;
  end

  // Timer increment and the two low time base bits per prescale ratio
  always_comb
  begin
    tb.tick     = 1'b0;
    tb.low_bits = phase;
    unique case (tb.prescale_sel)
      `PRESC_DIV1:
      begin
        tb.tick     = step && phase == `PHASE_LAST;
        tb.low_bits = phase;
      end
      `PRESC_DIV4:
      begin
        tb.tick     = step && phase == `PHASE_LAST && presc[1:0] == 2'h3;
        tb.low_bits = presc[1:0];
      end
      default:
      begin
        tb.tick     = step && phase == `PHASE_LAST && presc == `PRESC_LAST;
        tb.low_bits = presc[3:2];
      end
    endcase
  end

  // The timer only steps as the low bits wrap, keeping the 10-bit base monotonic
  property p_tick_at_wrap;
    @(posedge clk_sys) disable iff (!arst_n)
    tb.tick |-> (tb.low_bits == 2'h3 && phase == `PHASE_LAST);
  endproperty
  a_tick_at_wrap: assert property (p_tick_at_wrap)
    else $error("Timer tick while low bits not at their last value");
endmodule : pwm_timebase_gen

// ===== tb/pwm_load_model.sv
// External load on the PWM pin: measures high time and period in clk_sys cycles.
// Assumes a weak pull-down holds the wire low whenever the unit releases the pin.
`timescale 1ns/1ps
module pwm_load_model (
  input  wire logic   clk_sys,
  input  wire logic   pin,
  input  wire logic   pin_oe,
  output logic        level,
  output logic [15:0] high_len,
  output logic [15:0] period_len
);
  logic        prev = 1'b0;
  logic [15:0] since = 16'h0000;
  logic [15:0] high_run = 16'h0000;

  // Wire level; the pull-down wins when the driver is off
  assign level = pin_oe ? pin : 1'b0;

  // Rise to rise gives the period, rise to fall the high time
  always_ff @(posedge clk_sys)
  begin
    prev <= level;
    if (level && !prev)
    begin
      period_len <= since;
      since      <= 16'h0001;
      high_run   <= 16'h0001;
    end
    else
    begin
      since <= since + 16'h0001;
      if (level)
        high_run <= high_run + 16'h0001; // Stuck-high pin never reports a high time
    end
    if (!level && prev)
      high_len <= high_run;
  end
endmodule : pwm_load_model

// ===== tb/test_ccp_pwm_mode_generator.sv
// Self-checking bench of the PWM unit through its register port and a pin load.
// Assumes the register map of pwm_consts.svh and a 200 MHz clk_sys.
`timescale 1ns/1ps
`include "pwm_consts.svh"
module test_ccp_pwm_mode_generator;
  logic               clk_sys;
  logic               arst_n;
  pwm_pkg::reg_addr_t reg_addr;
  pwm_pkg::reg_byte_t reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  pwm_pkg::reg_byte_t reg_rdata;
  logic               sleep_req;
  logic               pin;
  logic               pin_oe;
  logic               alt_pin_sel;
  logic               timer_match_flag;
  logic               level;
  logic [15:0]        high_len;
  logic [15:0]        period_len;
  pwm_pkg::reg_byte_t c1;
  pwm_pkg::reg_byte_t c2;
  logic               lv;
  int                 errors = 0;
  int                 check_count = 0;
  int                 f;

  pwm_unit DUT (
    .clk_sys          (clk_sys),
    .arst_n           (arst_n),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .sleep_req        (sleep_req),
    .pwm_output_pin   (pin),
    .pwm_output_pin_oe(pin_oe),
    .alt_pin_sel      (alt_pin_sel),
    .timer_match_flag (timer_match_flag)
  );

  pwm_load_model load (
    .clk_sys   (clk_sys),
    .pin       (pin),
    .pin_oe    (pin_oe),
    .level     (level),
    .high_len  (high_len),
    .period_len(period_len)
  );

  // 200 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task complete_run;
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task waitc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : waitc

  // One-cycle write strobe; the write lands on the edge that ends the task
  task wr(input pwm_pkg::reg_addr_t a, input pwm_pkg::reg_byte_t d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data appears in the cycle after the strobe and holds until the next read
  task rd(input pwm_pkg::reg_addr_t a, output pwm_pkg::reg_byte_t d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task rdchk(input string what, input pwm_pkg::reg_addr_t a, input pwm_pkg::reg_byte_t e);
    pwm_pkg::reg_byte_t d;
    rd(a, d);
    check(what, d, e);
  endtask : rdchk

  // Counts cycles where the wire leaves the expected level
  task pin_hold(input logic v, input int n);
    int bad;
    bad = 0;
    repeat (n)
    begin
      @(posedge clk_sys);
      #1 if (level !== v) bad++;
    end
    check("pin hold", 16'(bad), 16'h0000);
  endtask : pin_hold

  // Bounded wait for a wire level
  task wait_level(input logic v);
    int n;
    n = 0;
    while (level !== v && n < 600)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask : wait_level

  // Watchdog well beyond the roughly 5400 cycles the tests take
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    errors++;
    complete_run();
  end

  initial
  begin
    arst_n    = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    sleep_req = 1'b0;
    waitc(6);
    arst_n <= 1'b1;
    // Defaults, with one unmapped address at the end
    for (int a = 0; a < 10; a++)
      rdchk("reset value", a[3:0], (a == 7) ? 8'h01 : 8'h00);
    check("oe after reset", pin_oe, 16'h0000);
    // Set-up order with pin driver off until the first match
    wr(`ADDR_PIN_DIRECTION, 8'h01);
    wr(`ADDR_PERIOD_LIMIT, 8'h03);
    wr(`ADDR_UNIT_CONTROL, 8'h2c);
    wr(`ADDR_DUTY_HIGH_BYTE, 8'h01);
    wr(`ADDR_MATCH_STATUS, 8'h00);
    wr(`ADDR_TIMER_CONTROL, 8'h04);
    f = 0;
    while (timer_match_flag !== 1'b1 && f < 100)
    begin
      @(posedge clk_sys);
      #1 f++;
    end
    check("match flag", timer_match_flag, 16'h0001);
    wr(`ADDR_PIN_DIRECTION, 8'h00);
    #1 check("oe enabled", pin_oe, 16'h0001);
    // New duty written mid-period must wait for the boundary
    wait_level(1'b0);
    wait_level(1'b1);
    wr(`ADDR_DUTY_HIGH_BYTE, 8'h02);
    rdchk("shadow held", `ADDR_DUTY_SHADOW_BYTE, 8'h01);
    wr(`ADDR_DUTY_SHADOW_BYTE, 8'hff);
    waitc(40);
    rdchk("shadow loaded", `ADDR_DUTY_SHADOW_BYTE, 8'h02);
    check("high time", high_len, 16'd10);
    check("period", period_len, 16'd16);
    // Every prescale code, postscale set to show it has no effect
    for (int p = 0; p < 4; p++)
    begin
      f = (p == 0) ? 1 : (p == 1) ? 4 : 16;
      wr(`ADDR_TIMER_CONTROL, {1'b0, 4'hf, 1'b1, p[1:0]});
      waitc(3 * 16 * f + 20);
      check("period prescaled", period_len, 16'(16 * f));
      check("high prescaled", high_len, 16'(10 * f));
    end
    wr(`ADDR_TIMER_CONTROL, 8'h04);
    // Full ten-bit resolution at the largest period
    wr(`ADDR_PERIOD_LIMIT, 8'hff);
    wr(`ADDR_DUTY_HIGH_BYTE, 8'hff);
    wr(`ADDR_UNIT_CONTROL, 8'h3c);
    waitc(3100);
    check("full period", period_len, 16'd1024);
    check("full high", high_len, 16'd1023);
    // Duty beyond the period never clears the pin
    wr(`ADDR_UNIT_CONTROL, 8'h0c);
    wr(`ADDR_DUTY_HIGH_BYTE, 8'h20);
    wr(`ADDR_PERIOD_LIMIT, 8'h03);
    wr(`ADDR_TIMER_COUNT, 8'h00);
    waitc(40);
    pin_hold(1'b1, 48);
    // Zero duty never sets the pin
    wr(`ADDR_DUTY_HIGH_BYTE, 8'h00);
    waitc(40);
    pin_hold(1'b0, 48);
    // Sleep freezes timer and pin, wake resumes
    wr(`ADDR_DUTY_HIGH_BYTE, 8'h01);
    wr(`ADDR_UNIT_CONTROL, 8'h2c);
    waitc(40);
    @(posedge clk_sys) sleep_req <= 1'b1;
    waitc(4);
    rd(`ADDR_TIMER_COUNT, c1);
    lv = level;
    waitc(20);
    rd(`ADDR_TIMER_COUNT, c2);
    check("count frozen", c2, c1);
    check("pin frozen", level, lv);
    @(posedge clk_sys) sleep_req <= 1'b0;
    waitc(8);
    rd(`ADDR_TIMER_COUNT, c2);
    check("count resumes", c2 !== c1, 16'h0001);
    // Only the PWM mode codes, any mode with both top bits set, drive the pin
    wr(`ADDR_UNIT_CONTROL, 8'h28);
    #1 check("oe other mode", pin_oe, 16'h0000);
    wr(`ADDR_UNIT_CONTROL, 8'h2c);
    #1 check("oe pwm mode", pin_oe, 16'h0001);
    wr(`ADDR_PIN_FUNCTION, 8'h01);
    #1 check("alt pin", alt_pin_sel, 16'h0001);
    // Reset in mid-run
    @(posedge clk_sys) arst_n <= 1'b0;
    waitc(3);
    check("oe in reset", pin_oe, 16'h0000);
    check("flag in reset", timer_match_flag, 16'h0000);
    check("alt in reset", alt_pin_sel, 16'h0000);
    @(posedge clk_sys) arst_n <= 1'b1;
    rdchk("direction again", `ADDR_PIN_DIRECTION, 8'h01);
    rdchk("period again", `ADDR_PERIOD_LIMIT, 8'h00);
    complete_run();
  end
endmodule : test_ccp_pwm_mode_generator
